// ===== pcl_pkg.sv
/*
 Shared constants, states and carriers of the parallel configuration
 load handshake. Assumes a 40 MHz system clock and a 32-bit data bus.
*/
package pcl_pkg;
    // System clock rate in kHz, 40 MHz
    localparam int CLK_KHZ      = 40000;
    // Power-on-reset delays in ms, the least of each window
    localparam int POR_FAST_MS  = 4;
    localparam int POR_STD_MS   = 100;
    // Power-on-reset counter width
    localparam int POR_CNT_W    = 24;

    // Register offsets, byte addresses
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_IMG  = 5'h04;
    localparam logic [4:0] OFS_STAT = 5'h08;
    localparam logic [4:0] OFS_WCNT = 5'h0c;
    localparam logic [4:0] OFS_IRQ  = 5'h10;
    localparam logic [4:0] OFS_MASK = 5'h14;
    localparam logic [4:0] OFS_LAST = 5'h18;

    // Values after reset
    localparam logic [3:0]  RST_RATIO = 4'h2;
    localparam logic [23:0] RST_IMG   = 24'h000010;
    localparam logic [3:0]  RST_MASK  = 4'h0;

    // Field positions
    localparam int INIT_EN_BIT  = 0;  // Option bit in the first word
    localparam int POR_SEL_BIT  = 0;  // Mode pin choosing fast delay
    // Falling edges that end initialization and enter user mode
    localparam logic [1:0] INIT_FALLS = 2'h2;

    // Interrupt bit positions
    localparam int IRQ_LOAD  = 0;
    localparam int IRQ_DONE  = 1;
    localparam int IRQ_USER  = 2;
    localparam int IRQ_ABORT = 3;
    localparam int IRQ_W     = 4;

    // Handshake states
    typedef enum logic [2:0] {
        ST_POR,
        ST_REQ,
        ST_LOAD,
        ST_INIT,
        ST_USER
    } pcl_state_t;

    // Pins coming from the host
    typedef struct packed {
        logic        request_n;
        logic        config_clock;
        logic [4:0]  mode_select_pins;
        logic [31:0] data;
    } pcl_pins_t;

    // Register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [31:0] wdata;
    } pcl_bus_t;
endpackage

// ===== pcl_loader.sv
/*
 Device end of the fast parallel configuration load handshake.
 Assumes host pins are asynchronous to mclk and that the host
 configuration clock is well below a quarter of the mclk rate.
*/
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
module pcl_loader #(
    parameter int POR_FAST_CYC = pcl_pkg::POR_FAST_MS * pcl_pkg::CLK_KHZ,
    parameter int POR_STD_CYC  = pcl_pkg::POR_STD_MS * pcl_pkg::CLK_KHZ
) (
    input  wire logic              mclk,
    input  wire logic              arst_n,
    input  wire pcl_pkg::pcl_pins_t pins,
    input  wire logic              status_line_i,
    input  wire pcl_pkg::pcl_bus_t  bus,
    output logic [31:0]            rdata,
    output logic                   status_line_o,
    output logic                   status_line_oe,
    output logic                   load_done_o,
    output logic                   load_done_oe,
    output logic                   init_done_o,
    output logic                   init_done_oe,
    output logic                   irq
);
    // Counter end values for both delays
    localparam logic [pcl_pkg::POR_CNT_W-1:0] FAST_LIM =
        pcl_pkg::POR_CNT_W'(POR_FAST_CYC - 1);
    localparam logic [pcl_pkg::POR_CNT_W-1:0] STD_LIM =
        pcl_pkg::POR_CNT_W'(POR_STD_CYC - 1);

    // True in states where the status line is pulled low
    function automatic logic holds_status(input pcl_pkg::pcl_state_t s);
        holds_status = (s == pcl_pkg::ST_POR) || (s == pcl_pkg::ST_REQ);
    endfunction

    // True in states where the done line is pulled low
    function automatic logic holds_done(input pcl_pkg::pcl_state_t s);
        holds_done = (s == pcl_pkg::ST_POR) || (s == pcl_pkg::ST_REQ) ||
                     (s == pcl_pkg::ST_LOAD);
    endfunction

    // Synchroniser stages
    logic        req_s1_r;      // Request, first stage
    logic        req_s2_r;      // Request, synced
    logic        clk_s1_r;      // Config clock, first stage
    logic        clk_s2_r;      // Config clock, synced
    logic        clk_s3_r;      // Config clock, previous sample
    logic [31:0] dat_s1_r;      // Data, first stage
    logic [31:0] dat_s2_r;      // Data, synced
    logic [4:0]  ms_s1_r;       // Mode pins, first stage
    logic [4:0]  ms_s2_r;       // Mode pins, synced
    logic        st_s1_r;       // Status line, first stage
    logic        st_s2_r;       // Status line, synced

    // Handshake state
    pcl_pkg::pcl_state_t state_r;
    pcl_pkg::pcl_state_t state_nxt;
    logic [pcl_pkg::POR_CNT_W-1:0] por_cnt_r;  // Delay counter
    logic        mode_fast_r;   // Fast delay chosen
    logic [3:0]  rise_cnt_r;    // Rising edges inside a word
    logic [23:0] word_cnt_r;    // Words taken
    logic [23:0] word_cnt_nxt;
    logic [1:0]  fall_cnt_r;    // Falls after done
    logic [31:0] last_word_r;   // Most recent word

    // Pin drivers
    logic        status_oe_r;
    logic        done_oe_r;
    logic        init_oe_r;
    logic        low_r;         // Constant low drive level

    // Software registers
    logic [3:0]  ratio_r;       // Clocks per word
    logic [23:0] img_r;         // Words in the image
    logic [3:0]  irq_stat_r;    // Sticky events
    logic [3:0]  irq_mask_r;    // Event enables
    logic [31:0] rdata_r;
    logic        irq_r;

    // Decoded strobes
    logic        req_low;       // Host requests reconfiguration
    logic        rise;          // Config clock rising edge
    logic        fall;          // Config clock falling edge
    logic        grp_end;       // Last rising edge of a word
    logic        take;          // Word sampled now
    logic [3:0]  ev;            // Events this cycle

    assign req_low = !req_s2_r;
    assign rise    = clk_s2_r && !clk_s3_r;
    assign fall    = !clk_s2_r && clk_s3_r;
    // A ratio of zero or one ends each word on its own edge
    assign grp_end = rise && ((ratio_r <= 4'h1) ||
                     (rise_cnt_r == ratio_r - 4'h1));
    assign take    = rise && (rise_cnt_r == 4'h0) &&
                     (state_r == pcl_pkg::ST_LOAD);

    // Two-stage synchronisers for every host pin
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_s1_r <= 1'b1;
            req_s2_r <= 1'b1;
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            dat_s1_r <= 32'h0;
            dat_s2_r <= 32'h0;
            ms_s1_r  <= 5'h0;
            ms_s2_r  <= 5'h0;
            st_s1_r  <= 1'b1;
            st_s2_r  <= 1'b1;
        end
        else
        begin
            req_s1_r <= pins.request_n;
            req_s2_r <= req_s1_r;
            clk_s1_r <= pins.config_clock;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            dat_s1_r <= pins.data;
            dat_s2_r <= dat_s1_r;
            ms_s1_r  <= pins.mode_select_pins;
            ms_s2_r  <= ms_s1_r;
            st_s1_r  <= status_line_i;
            st_s2_r  <= st_s1_r;
        end
    end

    // Word count after this cycle
    always_comb
    begin
        word_cnt_nxt = word_cnt_r;
        if (state_r == pcl_pkg::ST_REQ || state_r == pcl_pkg::ST_POR)
            word_cnt_nxt = 24'h0;
        else if (take)
            word_cnt_nxt = word_cnt_r + 24'h1;
    end

    // Last fall count before user mode
    localparam logic [1:0] INIT_FALLS_M1 = pcl_pkg::INIT_FALLS - 2'h1;

    // Next handshake state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            // Power-on hold, request has no effect here
            pcl_pkg::ST_POR:
                if (por_cnt_r == (mode_fast_r ? FAST_LIM : STD_LIM))
                    state_nxt = pcl_pkg::ST_LOAD;
            // Request held low
            pcl_pkg::ST_REQ:
                if (!req_low)
                    state_nxt = pcl_pkg::ST_LOAD;
            // Streaming words
            pcl_pkg::ST_LOAD:
                if (req_low)
                    state_nxt = pcl_pkg::ST_REQ;
                else if (grp_end && word_cnt_nxt >= img_r)
                    state_nxt = pcl_pkg::ST_INIT;
            // Waiting for the start-up falls
            pcl_pkg::ST_INIT:
                if (req_low)
                    state_nxt = pcl_pkg::ST_REQ;
                else if (fall && fall_cnt_r == INIT_FALLS_M1)
                    state_nxt = pcl_pkg::ST_USER;
            // User operation
            pcl_pkg::ST_USER:
                if (req_low)
                    state_nxt = pcl_pkg::ST_REQ;
            default:
                state_nxt = pcl_pkg::ST_POR;
        endcase
    end

    // State register
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            state_r <= pcl_pkg::ST_POR;
        else
            state_r <= state_nxt;
    end

    // Power-on delay counter and captured mode pin
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            por_cnt_r   <= '0;
            mode_fast_r <= 1'b0;
        end
        else if (state_r == pcl_pkg::ST_POR)
        begin
            por_cnt_r   <= por_cnt_r + 1'b1;
            // Mode pins follow while the delay runs
            mode_fast_r <= ms_s2_r[pcl_pkg::POR_SEL_BIT];
        end
    end

    // Word sequencing on the config clock edges
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rise_cnt_r  <= 4'h0;
            word_cnt_r  <= 24'h0;
            last_word_r <= 32'h0;
        end
        else
        begin
            word_cnt_r <= word_cnt_nxt;
            // Group counter runs only while loading
            if (state_r != pcl_pkg::ST_LOAD)
                rise_cnt_r <= 4'h0;
            else if (grp_end)
                rise_cnt_r <= 4'h0;
            else if (rise)
                rise_cnt_r <= rise_cnt_r + 4'h1;
            // Data sampled on the first edge of a word
            if (take)
                last_word_r <= dat_s2_r;
        end
    end

    // Falling edges counted after done is released
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            fall_cnt_r <= 2'h0;
        else if (state_r != pcl_pkg::ST_INIT)
            fall_cnt_r <= 2'h0;
        else if (fall)
            fall_cnt_r <= fall_cnt_r + 2'h1;
    end

    // Open-drain drivers of status, done and init lines
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            status_oe_r <= 1'b1;
            done_oe_r   <= 1'b1;
            init_oe_r   <= 1'b0;
            low_r       <= 1'b0;
        end
        else
        begin
            low_r       <= 1'b0;
            status_oe_r <= holds_status(state_nxt);
            done_oe_r   <= holds_done(state_nxt);
            // Init line pulled low once its option bit arrives
            if (take && word_cnt_r == 24'h0 &&
                dat_s2_r[pcl_pkg::INIT_EN_BIT])
                init_oe_r <= 1'b1;
            else if (state_nxt == pcl_pkg::ST_USER ||
                     state_nxt == pcl_pkg::ST_REQ)
                init_oe_r <= 1'b0;
        end
    end

    // Events of this cycle
    always_comb
    begin
        ev = 4'h0;
        ev[pcl_pkg::IRQ_LOAD]  = (state_nxt == pcl_pkg::ST_LOAD) &&
                                 (state_r != pcl_pkg::ST_LOAD);
        ev[pcl_pkg::IRQ_DONE]  = (state_nxt == pcl_pkg::ST_INIT) &&
                                 (state_r != pcl_pkg::ST_INIT);
        ev[pcl_pkg::IRQ_USER]  = (state_nxt == pcl_pkg::ST_USER) &&
                                 (state_r != pcl_pkg::ST_USER);
        ev[pcl_pkg::IRQ_ABORT] = (state_nxt == pcl_pkg::ST_REQ) &&
                                 (state_r != pcl_pkg::ST_REQ);
    end

    // Control registers written by software
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ratio_r    <= pcl_pkg::RST_RATIO;
            img_r      <= pcl_pkg::RST_IMG;
            irq_mask_r <= pcl_pkg::RST_MASK;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                pcl_pkg::OFS_CTRL: ratio_r    <= bus.wdata[3:0];
                pcl_pkg::OFS_IMG:  img_r      <= bus.wdata[23:0];
                pcl_pkg::OFS_MASK: irq_mask_r <= bus.wdata[3:0];
                default:           ratio_r    <= ratio_r;
            endcase
        end
    end

    // Sticky events, a new event wins over a clear
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_stat_r <= 4'h0;
        else if (bus.wr && bus.addr == pcl_pkg::OFS_IRQ)
            irq_stat_r <= (irq_stat_r & ~bus.wdata[3:0]) | ev;
        else
            irq_stat_r <= irq_stat_r | ev;
    end

    // Interrupt level
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // Read data, valid the cycle after the strobe
    always_ff @(posedge mclk or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= 32'h0;
        else if (bus.rd)
        begin
            case (bus.addr)
                pcl_pkg::OFS_CTRL: rdata_r <= {28'h0, ratio_r};
                pcl_pkg::OFS_IMG:  rdata_r <= {8'h0, img_r};
                pcl_pkg::OFS_STAT: rdata_r <= {22'h0, mode_fast_r,
                    st_s2_r, req_s2_r, init_oe_r, done_oe_r,
                    status_oe_r, 1'b0, state_r};
                pcl_pkg::OFS_WCNT: rdata_r <= {8'h0, word_cnt_r};
                pcl_pkg::OFS_IRQ:  rdata_r <= {28'h0, irq_stat_r};
                pcl_pkg::OFS_MASK: rdata_r <= {28'h0, irq_mask_r};
                pcl_pkg::OFS_LAST: rdata_r <= last_word_r;
                default:           rdata_r <= 32'h0;
            endcase
        end
        else
            rdata_r <= 32'h0;
    end

    // Outputs straight from flops
    assign rdata          = rdata_r;
    assign status_line_o  = low_r;
    assign status_line_oe = status_oe_r;
    assign load_done_o    = low_r;
    assign load_done_oe   = done_oe_r;
    assign init_done_o    = low_r;
    assign init_done_oe   = init_oe_r;
    assign irq            = irq_r;

    // Checks on the handshake
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    // Leaving the power-on hold
    sequence s_por_exit;
        $past(state_r) == pcl_pkg::ST_POR && state_r == pcl_pkg::ST_LOAD;
    endsequence

    // First word carrying the init option
    sequence s_opt_word;
        take && word_cnt_r == 24'h0 && dat_s2_r[pcl_pkg::INIT_EN_BIT];
    endsequence

    // Last start-up fall seen
    sequence s_last_fall;
        state_r == pcl_pkg::ST_INIT && !req_low && fall &&
        fall_cnt_r == INIT_FALLS_M1;
    endsequence

    a_user_lines_high: assert property (
        state_r == pcl_pkg::ST_USER |->
        !status_oe_r && !done_oe_r && !init_oe_r)
        else $error("lines not released in user mode");
    a_por_holds_low: assert property (
        state_r == pcl_pkg::ST_POR |-> status_oe_r)
        else $error("status released during power-on hold");
    a_por_fast_delay: assert property (
        s_por_exit ##0 $past(mode_fast_r) |->
        $past(por_cnt_r) == FAST_LIM ##1 !status_oe_r)
        else $error("fast power-on delay wrong");
    a_por_std_delay: assert property (
        s_por_exit ##0 !$past(mode_fast_r) |->
        $past(por_cnt_r) == STD_LIM ##1 !status_oe_r)
        else $error("standard power-on delay wrong");
    a_done_held_low: assert property (
        holds_done(state_r) |-> done_oe_r)
        else $error("done line released during configuration");
    a_done_after_all: assert property (
        $fell(done_oe_r) |-> word_cnt_r >= img_r)
        else $error("done released before the last word");
    a_request_restart: assert property (
        req_low && state_r != pcl_pkg::ST_POR |=>
        state_r == pcl_pkg::ST_REQ ##0 status_oe_r && done_oe_r
        ##1 word_cnt_r == 24'h0)
        else $error("request did not restart configuration");
    a_init_opt_low: assert property (
        s_opt_word |=> init_oe_r)
        else $error("init line not pulled low after option");
    a_user_after_falls: assert property (
        s_last_fall |=> state_r == pcl_pkg::ST_USER ##1 !done_oe_r)
        else $error("user mode not entered after falls");
    a_irq_follows: assert property (
        |(irq_stat_r & irq_mask_r) |=> irq_r)
        else $error("interrupt not raised");
endmodule

// ===== pcl_host_model.sv
/*
 Behavioural model of the configuration host that sits on the far
 side of the loader. It drives request, config clock and data words.
 Assumes the bench sums the open-drain wires and passes their levels.
*/
`timescale 1ns/1ps
module pcl_host_model (
    input  wire logic        status_level,
    input  wire logic        done_level,
    output logic             request_n,
    output logic             config_clock,
    output logic [31:0]      data
);
    // Idle levels: no request, clock parked low
    initial
    begin
        request_n = 1'b1;
        config_clock = 1'b0;
        data = 32'h0;
    end

    // Pull request low and leave it there
    task automatic drop_request();
        request_n = 1'b0;
    endtask

    // Request pulse, bounded wait for status release, settle gap
    task automatic restart(output bit ok);
        int n;
        request_n = 1'b0;
        #2000;
        request_n = 1'b1;
        n = 0;
        while (status_level !== 1'b1 && n < 200)
        begin
            #100;
            n++;
        end
        ok = (n < 200);
        #2000;
    endtask

    // One data word over ratio rising edges, optional low pause
    task automatic send_word(input logic [31:0] w, input int ratio,
                             input bit pause);
        int n;
        n = (ratio < 2) ? 1 : ratio;
        data = w;
        if (pause)
            #1500;
        #100;
        repeat (n)
        begin
            config_clock = 1'b1;
            #100;
            config_clock = 1'b0;
            #50;
            data = ~data;  // Hold over, bus no longer valid
            #50;
        end
    endtask

    // Two falling edges after done, clock then held low
    task automatic init_falls();
        // Init runs on the config clock, so the user init clock
        // option and its long run of cycles never comes into play
        repeat (2)
        begin
            config_clock = 1'b1;
            #100;
            config_clock = 1'b0;
            #100;
        end
    endtask
endmodule

// ===== parallel_config_load_handshake_test.sv
/*
 Self-checking bench for the parallel configuration loader.
 Assumes the host model above and pull-ups on the open-drain lines.
*/
`timescale 1ns/1ps
module parallel_config_load_handshake_test;
    localparam int FAST = 20;  // Shortened fast power-on count
    localparam int STD  = 40;  // Shortened standard power-on count
    typedef struct {
        int          ratio;
        int          words;
        logic [31:0] first;
        bit          pause;
    } pcl_case_t;
    logic               mclk;
    logic               arst_n;
    logic [4:0]         mode_pins;
    pcl_pkg::pcl_bus_t  bus;
    pcl_pkg::pcl_pins_t pins;
    logic [31:0]        rdata, h_data;
    logic               st_o, st_oe, dn_o, dn_oe, in_o, in_oe, irq;
    logic               h_req_n, h_clk, status_wire, done_wire;
    int                 num_errors, total_checks;

    // Wire levels: pulled up unless the device pulls low
    assign pins = {h_req_n, h_clk, mode_pins, h_data};
    assign status_wire = st_oe ? st_o : 1'b1;
    assign done_wire = dn_oe ? dn_o : 1'b1;

    pcl_loader #(.POR_FAST_CYC(FAST), .POR_STD_CYC(STD)) dut_u (
        .mclk(mclk), .arst_n(arst_n), .pins(pins),
        .status_line_i(status_wire), .bus(bus), .rdata(rdata),
        .status_line_o(st_o), .status_line_oe(st_oe),
        .load_done_o(dn_o), .load_done_oe(dn_oe),
        .init_done_o(in_o), .init_done_oe(in_oe), .irq(irq));
    pcl_host_model host_u (
        .status_level(status_wire), .done_level(done_wire),
        .request_n(h_req_n), .config_clock(h_clk), .data(h_data));

    // 40 MHz system clock
    initial
        mclk = 1'b0;
    always
        #12.5 mclk = ~mclk;

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string msg);
        total_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch %0t %s", $time, msg);
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Register write, one strobe cycle
    task automatic bus_wr(input logic [4:0] a, input logic [31:0] v);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge mclk);
        bus <= '0;
    endtask

    // Register read, data taken in the following cycle
    task automatic bus_rd(input logic [4:0] a, output logic [31:0] v);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge mclk);
        bus <= '0;
        #1;
        v = rdata;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    // Count edges until status is released, bounded
    task automatic por_check(input int cyc);
        int n;
        n = 0;
        while (st_oe !== 1'b0 && n < 200)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(32'(n >= cyc && n <= cyc + 3), 32'h1, "power-on delay");
        if (n >= 200)
            final_report();
    endtask

    // Watchdog against a hang
    initial
    begin
        #1000000;
        num_errors++;
        final_report();
    end

    // Main sequence
    initial
    begin
        static pcl_case_t rows [4] = '{'{1, 1, 32'h0000_0001, 1'b0},
            '{2, 3, 32'ha5a5_0000, 1'b1}, '{4, 2, 32'h1234_5671, 1'b0},
            '{3, 1, 32'hffff_fffe, 1'b0}};
        logic [31:0] d;
        bit ok;
        num_errors = 0;
        total_checks = 0;
        arst_n = 1'b0;
        mode_pins = 5'h01;
        bus = '0;
        repeat (16) @(posedge mclk);
        check({st_oe, dn_oe, in_oe, irq}, 32'hc, "reset lines");
        check({st_o, dn_o, in_o}, 32'h0, "drive levels");
        arst_n <= 1'b1;
        por_check(FAST);
        bus_rd(pcl_pkg::OFS_CTRL, d);
        check(d[3:0], 32'(pcl_pkg::RST_RATIO), "ctrl reset");
        bus_rd(pcl_pkg::OFS_IMG, d);
        check(d[23:0], 32'(pcl_pkg::RST_IMG), "image reset");
        bus_rd(pcl_pkg::OFS_MASK, d);
        check(d[3:0], 32'(pcl_pkg::RST_MASK), "mask reset");
        // Standard delay chosen by the mode pins
        @(posedge mclk);
        arst_n <= 1'b0;
        mode_pins <= 5'h00;
        wait_cyc(4);
        @(posedge mclk);
        arst_n <= 1'b1;
        por_check(STD);
        // Ordinary loads, one row each
        foreach (rows[k])
        begin
            bus_wr(pcl_pkg::OFS_CTRL, 32'(rows[k].ratio));
            bus_wr(pcl_pkg::OFS_IMG, 32'(rows[k].words));
            host_u.restart(ok);
            check(32'(ok), 32'h1, "status not released");
            for (int i = 0; i < rows[k].words; i++)
            begin
                check(dn_oe, 32'h1, "done early");
                host_u.send_word(rows[k].first + 32'(i), rows[k].ratio,
                                 rows[k].pause && i == 1);
            end
            wait_cyc(8);
            check(dn_oe, 32'h0, "done not released");
            check(in_oe, rows[k].first[0], "init option");
            bus_rd(pcl_pkg::OFS_WCNT, d);
            check(d, 32'(rows[k].words), "word count");
            bus_rd(pcl_pkg::OFS_LAST, d);
            check(d, rows[k].first + 32'(rows[k].words - 1), "last");
            host_u.init_falls();
            wait_cyc(8);
            check({st_oe, dn_oe, in_oe}, 32'h0, "user lines");
            check({h_req_n, status_wire, done_wire}, 32'h7, "wires");
            bus_rd(pcl_pkg::OFS_STAT, d);
            check(d[2:0], 32'h4, "user state");
        end
        // Request dropped in mid-load
        bus_wr(pcl_pkg::OFS_IMG, 32'h3);
        host_u.restart(ok);
        host_u.send_word(32'h0bad_0001, 2, 1'b0);
        host_u.drop_request();
        wait_cyc(6);
        check({st_oe, dn_oe}, 32'h3, "abort lines");
        check({status_wire, done_wire}, 32'h0, "abort wires");
        bus_rd(pcl_pkg::OFS_STAT, d);
        check(d[2:0], 32'h1, "abort state");
        bus_rd(pcl_pkg::OFS_WCNT, d);
        check(d, 32'h0, "count cleared");
        host_u.restart(ok);
        bus_wr(pcl_pkg::OFS_STAT, 32'h0);
        bus_rd(pcl_pkg::OFS_STAT, d);
        check(d[2:0], 32'h2, "reload state");
        bus_rd(5'h1c, d);
        check(d, 32'h0, "unmapped read");
        // Events: sticky, masked, cleared by ones
        bus_rd(pcl_pkg::OFS_IRQ, d);
        check(d[3:0], 32'hf, "event bits");
        check(irq, 32'h0, "masked irq");
        bus_wr(pcl_pkg::OFS_MASK, 32'h8);
        wait_cyc(2);
        check(irq, 32'h1, "abort irq");
        bus_wr(pcl_pkg::OFS_IRQ, 32'hf);
        wait_cyc(2);
        check(irq, 32'h0, "cleared irq");
        bus_rd(pcl_pkg::OFS_IRQ, d);
        check(d[3:0], 32'h0, "events cleared");
        final_report();
    end
endmodule
